// file: rtl/nsc_defs.svh
// Constants for the node switch configuration decoder
`ifndef NSC_DEFS_SVH
`define NSC_DEFS_SVH
// APB register byte offsets
`define NSC_OFF_RAW 12'h000
`define NSC_OFF_MODE 12'h004
`define NSC_OFF_SIZE 12'h008
`define NSC_OFF_IP 12'h00c
`define NSC_OFF_CTRL 12'h010
// Process image extension bit counts
`define NSC_DIAG_BITS 8'h10
`define NSC_STAT_BITS 8'h10
`define NSC_STAT_USED 8'h08
// Controller exchange sizes in bytes
`define NSC_XCHG_SMALL 8'h08
`define NSC_XCHG_LARGE 8'h10
// Fixed address network prefix
`define NSC_NET_PREFIX 24'hc0a801
// Switch three values that do not select fixed addressing
`define NSC_IP_ZERO 8'h00
`define NSC_IP_ALLONES 8'hff
// Sampling settle time after reset release, in ns
`define NSC_SETTLE_NS 1000
`define NSC_CLK_NS 100
`define NSC_SETTLE_CYC ((`NSC_SETTLE_NS + `NSC_CLK_NS - 1) / `NSC_CLK_NS)
`define NSC_CNT_W 4
// Flops between the switch pins and the capture register
`define NSC_SYNC_DEPTH 2
`endif

// file: rtl/nsc_pkg.sv
// Types for the node switch configuration decoder
package nsc_pkg;
   typedef enum logic [1:0] {
      NSC_MODE_REMOTE_IO,
      NSC_MODE_REMOTE_CTRL,
      NSC_MODE_RSVD
   } nsc_mode_t;
   typedef enum logic [1:0] {
      NSC_DIAG_OFF,
      NSC_DIAG_IFACE,
      NSC_DIAG_STATUS,
      NSC_DIAG_RSVD
   } nsc_diag_t;
   typedef enum logic [1:0] {
      NSC_IP_DYNAMIC,
      NSC_IP_STORED,
      NSC_IP_FIXED
   } nsc_ipmode_t;
   typedef enum logic [1:0] {
      NSC_ST_SETTLE,
      NSC_ST_SAMPLE,
      NSC_ST_HOLD
   } nsc_state_t;
endpackage

// file: rtl/nsc_switch_decode.sv
// Switch bank decoder with APB status view
//
// Contract
// RULE_01 - Both mode elements off: remote I/O
// RULE_02 - Element one on, two off: remote controller
// RULE_03 - Switch two meaning depends on mode
// RULE_04 - Remote I/O, both off: no extras
// RULE_05 - Element one on: diagnostic interface, 16 bits
// RULE_06 - Element two on: status bits, 8 used
// RULE_07 - Both on in remote I/O: reserved
// RULE_08 - Controller exchange 8 or 16 bytes
// RULE_09 - Switch three gives addressing type
// RULE_10 - All off: dynamic unless stored settings
// RULE_11 - Other than 0/255: fixed 192.168.1.x
// RULE_12 - Sample once after reset, then hold
//
// The APB interface to the registers and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`include "nsc_defs.svh"
module nsc_switch_decode
   import nsc_pkg::*;
#(
   parameter int SETTLE_CYC = `NSC_SETTLE_CYC
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Switch bank pins
   input wire logic mode_switch_elem_one,
   input wire logic mode_switch_elem_two,
   input wire logic [1:0] diag_switch,
   input wire logic [7:0] ip_switch,
   // Stored network settings present in non-volatile memory
   input wire logic nv_settings_valid,
   // Decoded settings
   output logic cfg_valid,
   output logic remote_ctrl_mode,
   output logic ctrl_passive,
   output logic diag_iface_en,
   output logic status_bits_en,
   output logic [7:0] extra_in_bits,
   output logic [7:0] extra_out_bits,
   output logic [7:0] xchg_bytes,
   output logic cfg_reserved,
   output logic [1:0] ip_mode,
   output logic [31:0] ip_addr
);

   // Pins are asynchronous; two flops before any use
   logic [11:0] sw_s1_r;
   logic [11:0] sw_s2_r;
   logic nv_s1_r;
   logic nv_s2_r;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sw_s1_r <= 12'h000;
         sw_s2_r <= 12'h000;
         nv_s1_r <= 1'b0;
         nv_s2_r <= 1'b0;
      end else begin
         sw_s1_r <= {ip_switch, diag_switch,
                     mode_switch_elem_two, mode_switch_elem_one};
         sw_s2_r <= sw_s1_r;
         nv_s1_r <= nv_settings_valid;
         nv_s2_r <= nv_s1_r;
      end
   end

   // Sampling sequence: settle, sample once, hold forever
   nsc_state_t state_r;
   logic [`NSC_CNT_W-1:0] cnt_r;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_r <= NSC_ST_SETTLE;
         cnt_r <= '0;
      end else begin
         unique case (state_r)
            NSC_ST_SETTLE: begin
               // Never sample before the synchroniser holds real pins
               if (cnt_r >= `NSC_CNT_W'(SETTLE_CYC - 1)
                  && cnt_r >= `NSC_CNT_W'(`NSC_SYNC_DEPTH - 1)) begin
                  state_r <= NSC_ST_SAMPLE;
               end else begin
                  cnt_r <= cnt_r + `NSC_CNT_W'(1);
               end
            end
            NSC_ST_SAMPLE: begin
               state_r <= NSC_ST_HOLD; // RULE_12
            end
            NSC_ST_HOLD: begin
               state_r <= NSC_ST_HOLD; // RULE_12
            end
         endcase
      end
   end

   // Captured raw switch image
   logic [11:0] raw_r;
   logic nv_r;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         raw_r <= 12'h000;
         nv_r <= 1'b0;
      end else if (state_r == NSC_ST_SAMPLE) begin
         raw_r <= sw_s2_r; // RULE_12
         nv_r <= nv_s2_r;
      end
   end

   // Decode of synchroniser output, registered only in the sample state
   logic m1;
   logic m2;
   logic [1:0] d;
   logic [7:0] ipsw;
   assign m1 = sw_s2_r[0];
   assign m2 = sw_s2_r[1];
   assign d = sw_s2_r[3:2];
   assign ipsw = sw_s2_r[11:4];

   logic rc_nxt;
   logic diag_nxt;
   logic stat_nxt;
   logic [7:0] xin_nxt;
   logic [7:0] xout_nxt;
   logic [7:0] xb_nxt;
   logic rsvd_nxt;
   logic [1:0] ipm_nxt;
   logic [31:0] ipa_nxt;
   always_comb begin
      rc_nxt = 1'b0;
      diag_nxt = 1'b0;
      stat_nxt = 1'b0;
      xin_nxt = 8'h00;
      xout_nxt = 8'h00;
      xb_nxt = 8'h00;
      rsvd_nxt = 1'b0;
      if (!m1 && !m2) begin
         // Remote I/O: switch two picks diagnostics
         unique case (d) // RULE_03
            2'b00: begin
               rsvd_nxt = 1'b0; // RULE_04
            end
            2'b01: begin
               diag_nxt = 1'b1; // RULE_05
               xin_nxt = `NSC_DIAG_BITS;
               xout_nxt = `NSC_DIAG_BITS;
            end
            2'b10: begin
               stat_nxt = 1'b1; // RULE_06
               xin_nxt = `NSC_STAT_BITS;
            end
            2'b11: begin
               rsvd_nxt = 1'b1; // RULE_07
            end
         endcase
      end else if (m1 && !m2) begin
         rc_nxt = 1'b1; // RULE_02
         // Controller: switch two picks exchange size
         unique case (d) // RULE_03
            2'b00: xb_nxt = `NSC_XCHG_SMALL; // RULE_08
            2'b10: xb_nxt = `NSC_XCHG_LARGE; // RULE_08
            default: rsvd_nxt = 1'b1; // RULE_08
         endcase
      end else begin
         // Undocumented mode codes fall back to remote I/O, flagged
         rsvd_nxt = 1'b1; // RULE_01
      end
   end

   always_comb begin
      ipa_nxt = 32'h0000_0000;
      if (ipsw == `NSC_IP_ZERO || ipsw == `NSC_IP_ALLONES) begin
         // Dynamic unless stored settings exist
         ipm_nxt = nv_s2_r ? 2'(NSC_IP_STORED)
                           : 2'(NSC_IP_DYNAMIC); // RULE_10
      end else begin
         ipm_nxt = 2'(NSC_IP_FIXED); // RULE_11
         ipa_nxt = {`NSC_NET_PREFIX, ipsw}; // RULE_11
      end
   end

   // Decoded outputs: loaded once, then frozen
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cfg_valid <= 1'b0;
         remote_ctrl_mode <= 1'b0;
         ctrl_passive <= 1'b1;
         diag_iface_en <= 1'b0;
         status_bits_en <= 1'b0;
         extra_in_bits <= 8'h00;
         extra_out_bits <= 8'h00;
         xchg_bytes <= 8'h00;
         cfg_reserved <= 1'b0;
         ip_mode <= 2'(NSC_IP_DYNAMIC); // RULE_09
         ip_addr <= 32'h0000_0000;
      end else if (state_r == NSC_ST_SAMPLE) begin
         cfg_valid <= 1'b1; // RULE_12
         remote_ctrl_mode <= rc_nxt; // RULE_01
         ctrl_passive <= !rc_nxt; // RULE_01
         diag_iface_en <= diag_nxt;
         status_bits_en <= stat_nxt;
         extra_in_bits <= xin_nxt;
         extra_out_bits <= xout_nxt;
         xchg_bytes <= xb_nxt;
         cfg_reserved <= rsvd_nxt;
         ip_mode <= ipm_nxt; // RULE_09
         ip_addr <= ipa_nxt;
      end
   end

   // Software-owned scratch control word
   logic [31:0] ctrl_r;
   logic wr_en;
   logic rd_en;
   assign wr_en = psel && penable && pwrite;
   assign rd_en = psel && !penable && !pwrite;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_r <= 32'h0000_0000;
      end else if (wr_en && paddr == `NSC_OFF_CTRL) begin
         ctrl_r <= pwdata;
      end
   end

   // APB answers with no wait state; read data latched at setup
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready <= psel && !penable;
         pslverr <= 1'b0;
         if (psel && !penable) begin
            pslverr <= !(paddr == `NSC_OFF_RAW || paddr == `NSC_OFF_MODE
               || paddr == `NSC_OFF_SIZE || paddr == `NSC_OFF_IP
               || paddr == `NSC_OFF_CTRL);
         end
         if (rd_en) begin
            unique case (paddr)
               `NSC_OFF_RAW: prdata <= {19'h0, nv_r, raw_r};
               `NSC_OFF_MODE: prdata <= {26'h0, cfg_reserved,
                  status_bits_en, diag_iface_en, ctrl_passive,
                  remote_ctrl_mode, cfg_valid};
               `NSC_OFF_SIZE: prdata <= {8'h0, xchg_bytes,
                  extra_out_bits, extra_in_bits};
               `NSC_OFF_IP: prdata <= ip_mode == 2'(NSC_IP_FIXED)
                  ? ip_addr : {30'h0, ip_mode};
               `NSC_OFF_CTRL: prdata <= ctrl_r;
               default: prdata <= 32'h0000_0000;
            endcase
         end
      end
   end

   // Checks
   a_hold_frozen: assert property (@(posedge pclk) disable iff (!presetn)
      cfg_valid |=> $stable(ip_addr) && $stable(remote_ctrl_mode)
      && $stable(xchg_bytes)) // RULE_12
      else $error("settings changed after sampling");
   a_sample_once: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(cfg_valid) |-> $past(state_r) == NSC_ST_SAMPLE) // RULE_12
      else $error("sample without sample state");
   a_passive_io: assert property (@(posedge pclk) disable iff (!presetn)
      cfg_valid |-> ctrl_passive == !remote_ctrl_mode) // RULE_01
      else $error("passive flag wrong");
   a_ctrl_mode: assert property (@(posedge pclk) disable iff (!presetn)
      cfg_valid && raw_r[1:0] == 2'b01 |-> remote_ctrl_mode) // RULE_02
      else $error("controller mode not decoded");
   a_mode_split: assert property (@(posedge pclk) disable iff (!presetn)
      cfg_valid && remote_ctrl_mode |-> !diag_iface_en && !status_bits_en)
      // RULE_03
      else $error("diagnostics in controller mode");
   a_diag_bits: assert property (@(posedge pclk) disable iff (!presetn)
      diag_iface_en |-> extra_in_bits == `NSC_DIAG_BITS
      && extra_out_bits == `NSC_DIAG_BITS) // RULE_05
      else $error("diagnostic width wrong");
   a_stat_bits: assert property (@(posedge pclk) disable iff (!presetn)
      status_bits_en |-> extra_in_bits == `NSC_STAT_BITS
      && extra_out_bits == 8'h00) // RULE_06
      else $error("status width wrong");
   a_xchg_size: assert property (@(posedge pclk) disable iff (!presetn)
      cfg_valid && raw_r[3:0] == 4'b1001 |-> xchg_bytes == `NSC_XCHG_LARGE)
      // RULE_08
      else $error("exchange size wrong");
   a_fixed_ip: assert property (@(posedge pclk) disable iff (!presetn)
      cfg_valid && ip_mode == 2'(NSC_IP_FIXED)
      |-> ip_addr[31:8] == `NSC_NET_PREFIX && ip_addr[7:0] == raw_r[11:4])
      // RULE_11
      else $error("fixed address wrong");
   a_dyn_ip: assert property (@(posedge pclk) disable iff (!presetn)
      cfg_valid && raw_r[11:4] == 8'h00 && !nv_r
      |-> ip_mode == 2'(NSC_IP_DYNAMIC)) // RULE_10
      else $error("dynamic addressing not chosen");
   a_apb_ready: assert property (@(posedge pclk) disable iff (!presetn)
      psel && !penable |=> pready)
      else $error("apb answer late");
   c_ctrl: cover property (@(posedge pclk) $rose(cfg_valid)
      && remote_ctrl_mode);
   c_diag: cover property (@(posedge pclk) $rose(cfg_valid)
      && diag_iface_en);
   c_fixed: cover property (@(posedge pclk) $rose(cfg_valid)
      && ip_mode == 2'(NSC_IP_FIXED));
   c_rsvd: cover property (@(posedge pclk) $rose(cfg_valid)
      && cfg_reserved);

endmodule

// file: tb/nsc_switch_bank.sv
// Installer's switch bank as seen at the node's pins
`timescale 1ns/1ps
module nsc_switch_bank (
   // Installer's settings {ip, mode two, switch two, mode one}
   input wire logic [11:0] pos,
   input wire logic allow_rsvd,
   // Switch pins
   output logic mode_one,
   output logic mode_two,
   output logic [1:0] diag,
   output logic [7:0] ip
);
   logic rsvd_pick;
   // Installer never sets the reserved remote I/O code unless told to
   assign rsvd_pick = !pos[0] && pos[2:1] == 2'h3 && !allow_rsvd;
   assign mode_one = pos[0];
   assign mode_two = pos[3];
   assign diag = rsvd_pick ? 2'h0 : pos[2:1];
   assign ip = pos[11:4];
endmodule

// file: tb/node_switch_config_decode_tb.sv
// Self-checking bench for the switch bank decoder
`timescale 1ns/1ps
`include "nsc_defs.svh"
module node_switch_config_decode_tb;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, ip_addr, lfsr = 32'h98b7;
   logic pready, pslverr, m1, m2, cfg_valid, rc_o, pas_o;
   logic diag_o, stat_o, rsvd_o, nv = 1'b0, allow = 1'b0;
   logic [1:0] dsw, ip_mode;
   logic [7:0] ipsw, ein_o, eout_o, xchg_o;
   logic [11:0] pos = 12'h000;
   logic [32:0] exp_q[$];
   int failures = 0, checks_done = 0, cycles = 0;

   always #50 pclk = ~pclk;

   nsc_switch_bank u_bank (.pos(pos), .allow_rsvd(allow), .mode_one(m1),
      .mode_two(m2), .diag(dsw), .ip(ipsw));

   nsc_switch_decode #(.SETTLE_CYC(1)) u_dut (.pclk(pclk),
      .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .mode_switch_elem_one(m1),
      .mode_switch_elem_two(m2), .diag_switch(dsw), .ip_switch(ipsw),
      .nv_settings_valid(nv), .cfg_valid(cfg_valid),
      .remote_ctrl_mode(rc_o), .ctrl_passive(pas_o),
      .diag_iface_en(diag_o), .status_bits_en(stat_o),
      .extra_in_bits(ein_o), .extra_out_bits(eout_o), .xchg_bytes(xchg_o),
      .cfg_reserved(rsvd_o), .ip_mode(ip_mode), .ip_addr(ip_addr));

   function automatic logic [31:0] step(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   task automatic chk(input logic [32:0] got, input logic [32:0] want);
      checks_done++;
      if (got !== want) begin
         failures++;
         $display("unexpected at %0t: got %h want %h", $time, got, want);
      end
   endtask

   task automatic chk_port(input logic [32:0] got,
      input logic [32:0] want);
      checks_done++;
      if (got !== want) begin
         failures++;
         $display("unexpected at %0t: got %h want %h", $time, got, want);
      end
   endtask

   task automatic conclude();
      if (failures == 0 && checks_done > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   // Reads note their expected {pslverr, prdata}; writes note nothing
   task automatic apb(input logic w, input logic [11:0] a,
      input logic [31:0] d, input logic [32:0] e);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      if (!w) exp_q.push_back(e);
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   always @(posedge pclk) begin
      if (psel && penable && pready === 1'b1 && !pwrite)
         chk({pslverr, prdata}, exp_q.pop_front());
   end

   always @(posedge pclk) begin
      cycles++;
      if (cycles == 3000) begin
         failures++;
         conclude();
      end
   end

   initial begin
      logic [7:0] ip, xb, ein, eout;
      logic rc, dg, st, rs, fix, e2, nvv;
      logic [1:0] d, ipm;
      for (int i = 0; i < 12; i++) begin
         lfsr = step(lfsr);
         d = i[1:0];
         rc = i[2] && !i[3];
         e2 = i[3] && !i[1];
         nvv = lfsr[9] && i != 0;
         ip = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : (i == 2) ? 8'h01
            : lfsr[7:0];
         presetn <= 1'b0;
         pos <= {ip, e2, d, rc};
         nv <= nvv;
         allow <= i != 11;
         // Told to keep clear, the installer leaves switch two off
         if (i == 11) d = 2'h0;
         repeat (10) @(posedge pclk);
         presetn <= 1'b1;
         for (int n = 0; n < 60 && cfg_valid !== 1'b1; n++)
            @(posedge pclk);
         // Switches moved under power must not reach the settings
         pos <= ~pos;
         nv <= ~nv;
         dg = !rc && !e2 && d == 2'h1;
         st = !rc && !e2 && d == 2'h2;
         rs = e2 || (rc ? d[0] : d == 2'h3);
         xb = !rc ? 8'h00 : (d == 2'h0) ? `NSC_XCHG_SMALL
            : (d == 2'h2) ? `NSC_XCHG_LARGE : 8'h00;
         ein = dg ? `NSC_DIAG_BITS : st ? `NSC_STAT_BITS : 8'h00;
         eout = dg ? `NSC_DIAG_BITS : 8'h00;
         fix = ip != `NSC_IP_ZERO && ip != `NSC_IP_ALLONES;
         ipm = fix ? 2'h2 : {1'b0, nvv};
         repeat (3) @(posedge pclk);
         apb(1'b0, `NSC_OFF_MODE, 32'h0,
            {27'h0, rs, st, dg, !rc, rc, 1'b1});
         apb(1'b0, `NSC_OFF_SIZE, 32'h0,
            {9'h0, xb, eout, ein});
         apb(1'b0, `NSC_OFF_RAW, 32'h0,
            {20'h0, nvv, ip, d, e2, rc});
         apb(1'b0, `NSC_OFF_IP, 32'h0, {1'b0, fix ? {`NSC_NET_PREFIX, ip}
            : {30'h0, ipm}});
         apb(1'b1, `NSC_OFF_CTRL, lfsr, 33'h0);
         apb(1'b0, `NSC_OFF_CTRL, 32'h0, {1'b0, lfsr});
         apb(1'b0, 12'h014, 32'h0, {1'b1, 32'h0});
         @(posedge pclk);
         chk_port({rsvd_o, xchg_o, eout_o, ein_o},
            {rs, xb, eout, ein});
         chk_port({29'h0, cfg_valid, pas_o, diag_o, stat_o},
            {29'h0, 1'b1, !rc, dg, st});
         chk_port({31'h0, rsvd_o, rc_o}, {31'h0, rs, rc});
         chk_port({31'h0, ip_mode}, {31'h0, ipm});
         chk_port({1'b0, ip_addr},
            fix ? {1'b0, `NSC_NET_PREFIX, ip} : 33'h0);
      end
      conclude();
   end
endmodule
